// ### aoc_pkg.sv
// Constants and types for the AND / compare opcode decoder
// Overview of operation
// - AC: accumulator AND immediate, immediate in byte two.
// - 7C, register nibble over 0011, immediate: register AND immediate.
// - Byte 6C: page-two location AND immediate, offset then immediate.
// - Prefix 3C means page one; 3C 6C, offset, immediate: page-one AND.
// - 01 6C, offset, immediate: special register AND immediate.
// - Byte 9C: accumulator AND page-two location, offset in byte two.
// - After 7C the low nibble picks page and read/write direction.
// - 2A, then 0x..3x over C: memory to memory, source offset first.
// - 07 then 2C load or AC store via word pointer; 3C adds page one.
// - 07 then 3C or BC: long pointer, accumulator or memory destination.
// - 0A 4C: accumulator AND 16-bit address, low byte then high byte.
// - 0A 5C: 24-bit address, bytes 23..16, then 7..0, then 15..8.
// - 0A CC and 0A DC: memory-destination absolute forms, 16 and 24 bit.
// - 16 then pointer-mode nibble over C: register-indirect forms.
// - 06 then base and direction nibble, then one displacement byte.
// - 0A with index nibble: 24-bit base, low, high, then top byte.
// - 17 then base-index nibble over C, no further bytes.
// - Compare uses the same layout with low nibble 1111 instead of 1100.
package aoc_pkg;
  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 7;
  localparam int BUS_W = BYTE_W * NUM_BYTES;

  // ***************************************************************
  // Prefixes and group first bytes
  // ***************************************************************
  localparam logic [7:0] PFX_PAGE1 = 8'h3C;
  localparam logic [7:0] PFX_SFR = 8'h01;
  localparam logic [7:0] GRP_MEMMEM = 8'h2A;
  localparam logic [7:0] GRP_IND = 8'h07;
  localparam logic [7:0] GRP_ABS = 8'h0A;
  localparam logic [7:0] GRP_REGIND = 8'h16;
  localparam logic [7:0] GRP_DISP = 8'h06;
  localparam logic [7:0] GRP_BASEIDX = 8'h17;

  // ***************************************************************
  // Nibble codes
  // ***************************************************************
  localparam logic [3:0] ALU_AND = 4'hC;
  localparam logic [3:0] ALU_CMP = 4'hF;
  localparam logic [3:0] HI_ACC_IMM = 4'hA;
  localparam logic [3:0] HI_REG = 4'h7;
  localparam logic [3:0] HI_MEM_IMM = 4'h6;
  localparam logic [3:0] HI_REG_REG = 4'h8;
  localparam logic [3:0] HI_ACC_SADDR = 4'h9;
  localparam logic [3:0] SEL_RD_P2 = 4'h0;
  localparam logic [3:0] SEL_RD_P1 = 4'h1;
  localparam logic [3:0] SEL_RD_SFR = 4'h2;
  localparam logic [3:0] SEL_IMM = 4'h3;
  localparam logic [3:0] SEL_WR_P2 = 4'h4;
  localparam logic [3:0] SEL_WR_P1 = 4'h5;
  localparam logic [3:0] SEL_WR_SFR = 4'h6;
  localparam logic [3:0] IND_WLOAD = 4'h2;
  localparam logic [3:0] IND_LLOAD = 4'h3;
  localparam logic [3:0] IND_WSTORE = 4'hA;
  localparam logic [3:0] IND_LSTORE = 4'hB;
  localparam logic [3:0] ABS16_LD = 4'h4;
  localparam logic [3:0] ABS24_LD = 4'h5;
  localparam logic [3:0] ABS16_ST = 4'hC;
  localparam logic [3:0] ABS24_ST = 4'hD;
  localparam logic [3:0] MEMMEM_LAST = 4'h3;
  localparam logic [2:0] DISP_LAST = 3'h4;
  localparam int DIR_BIT = 3;
  localparam int RSEL_ZERO_BIT = 3;

  // ***************************************************************
  // Body lengths in bytes, prefix excluded, and the one-byte prefix length
  // ***************************************************************
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;
  localparam logic [2:0] LEN_FIVE = 3'h5;
  localparam logic [2:0] LEN_PFX = 3'h1;

  // ***************************************************************
  // Decoded form and address space
  // ***************************************************************
  typedef enum logic [4:0] {
    FORM_ILLEGAL, FORM_ACC_IMM, FORM_REG_IMM, FORM_MEM_IMM, FORM_REG_REG,
    FORM_REG_REG2, FORM_ACC_SADDR, FORM_REG_MEM_RD, FORM_REG_MEM_WR,
    FORM_MEM_MEM, FORM_IND_WLOAD, FORM_IND_WSTORE, FORM_IND_LLOAD,
    FORM_IND_LSTORE, FORM_ABS16_LD, FORM_ABS24_LD, FORM_ABS16_ST,
    FORM_ABS24_ST, FORM_REGIND_LD, FORM_REGIND_ST, FORM_DISP_LD,
    FORM_DISP_ST, FORM_IDX24_LD, FORM_IDX24_ST, FORM_BASEIDX_LD,
    FORM_BASEIDX_ST
  } aoc_form_t;

  typedef enum logic [1:0] {
    SPC_NONE, SPC_PAGE2, SPC_PAGE1, SPC_SFR
  } aoc_space_t;
endpackage : aoc_pkg

// ### aoc_prefix_strip.sv
// Prefix stripper: flags a page-one or special-register prefix
`timescale 1ns/100ps
module aoc_prefix_strip (
  // Raw instruction bytes, first byte in the low lane
  input wire logic [aoc_pkg::BUS_W-1:0] bytes_i,
  // Prefix flags and bytes after the prefix
  output logic page1_o,
  output logic sfr_o,
  output logic [aoc_pkg::BUS_W-1:0] body_o
);
  import aoc_pkg::*;

  wire [7:0] first_byte = bytes_i[BYTE_W-1:0];
  wire has_pfx;

  // Page-one and special-register prefixes are a single byte each
  assign page1_o = (first_byte == PFX_PAGE1);
  assign sfr_o = (first_byte == PFX_SFR);
  assign has_pfx = page1_o | sfr_o;

  // Shift one byte lane down when a prefix is present; top lane fills zero
  genvar i;
  generate
    for (i = 0; i < NUM_BYTES; i++) begin : g_lane
      if (i == NUM_BYTES - 1) begin : g_top
        assign body_o[i*BYTE_W +: BYTE_W] =
          has_pfx ? '0 : bytes_i[i*BYTE_W +: BYTE_W];
      end else begin : g_mid
        assign body_o[i*BYTE_W +: BYTE_W] = has_pfx ?
          bytes_i[(i+1)*BYTE_W +: BYTE_W] : bytes_i[i*BYTE_W +: BYTE_W];
      end
    end
  endgenerate
endmodule : aoc_prefix_strip

// ### aoc_addr_pack.sv
// Address packer: orders three operand bytes into a 24-bit value
`timescale 1ns/100ps
module aoc_addr_pack (
  // Three operand bytes in stream order
  input wire logic [7:0] x0_i,
  input wire logic [7:0] x1_i,
  input wire logic [7:0] x2_i,
  // Ordering controls
  input wire logic top_first_i,
  input wire logic short_i,
  // Packed address
  output logic [23:0] addr_o
);
  // Long absolute addresses lead with bits 23..16, then low, then high
  wire [23:0] top_first = {x0_i, x2_i, x1_i};
  // Short addresses and 24-bit bases run low, high, then top
  wire [23:0] low_first = {short_i ? 8'h00 : x2_i, x1_i, x0_i};

  assign addr_o = top_first_i ? top_first : low_first;
endmodule : aoc_addr_pack

// ### aoc_decoder.sv
// AND and compare instruction decoder, one instruction per strobe
`timescale 1ns/100ps
module aoc_decoder (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Instruction from fetch, first byte in the low lane
  input wire logic insn_valid_i,
  input wire logic [aoc_pkg::BUS_W-1:0] insn_bytes_i,
  // Decode result, one-cycle strobe with held fields
  output logic dec_valid_o,
  output logic illegal_o,
  output logic is_cmp_o,
  output logic writes_dst_o,
  output aoc_pkg::aoc_form_t form_o,
  output aoc_pkg::aoc_space_t src_space_o,
  output aoc_pkg::aoc_space_t dst_space_o,
  output logic [2:0] length_o,
  // Operand fields
  output logic [3:0] reg_a_o,
  output logic [2:0] reg_b_o,
  output logic [3:0] mode_o,
  output logic [7:0] off_src_o,
  output logic [7:0] off_dst_o,
  output logic [7:0] imm_o,
  output logic [23:0] addr_o
);
  import aoc_pkg::*;

  // ***************************************************************
  // Byte lanes
  // ***************************************************************
  logic page1;
  logic sfr;
  logic [BUS_W-1:0] body;
  logic [7:0] cb [NUM_BYTES];
  logic [7:0] rb [NUM_BYTES];
  logic [23:0] packed_addr;

  aoc_prefix_strip u_strip (
    .bytes_i(insn_bytes_i),
    .page1_o(page1),
    .sfr_o(sfr),
    .body_o(body)
  );

  // Split raw and stripped streams into lanes
  genvar i;
  generate
    for (i = 0; i < NUM_BYTES; i++) begin : g_split
      assign cb[i] = body[i*BYTE_W +: BYTE_W];
      assign rb[i] = insn_bytes_i[i*BYTE_W +: BYTE_W];
    end
  endgenerate

  // Nibble views of the leading byte and the operation byte
  wire [3:0] hi0 = cb[0][7:4];
  wire [3:0] lo0 = cb[0][3:0];
  wire [3:0] hi1 = cb[1][7:4];
  wire [3:0] lo1 = cb[1][3:0];
  wire alu_single = (lo0 == ALU_AND) | (lo0 == ALU_CMP);
  // Group first bytes never end in C or F, so the two cases cannot clash
  wire [3:0] alu_nib = alu_single ? lo0 : lo1;
  wire alu_ok = (alu_nib == ALU_AND) | (alu_nib == ALU_CMP);
  wire pfx_any = page1 | sfr;
  wire page_space_p1 = page1;
  wire abs_top_first = (hi1 == ABS24_LD) | (hi1 == ABS24_ST);
  wire abs_short = (hi1 == ABS16_LD) | (hi1 == ABS16_ST);

  aoc_addr_pack u_pack (
    .x0_i(cb[2]),
    .x1_i(cb[3]),
    .x2_i(cb[4]),
    .top_first_i(abs_top_first),
    .short_i(abs_short),
    .addr_o(packed_addr)
  );

  // ***************************************************************
  // Form decode
  // ***************************************************************
  aoc_form_t next_form;
  aoc_space_t next_src;
  aoc_space_t next_dst;
  logic [2:0] next_len;
  logic [3:0] next_reg_a;
  logic [2:0] next_reg_b;
  logic [3:0] next_mode;
  logic [7:0] next_off_src;
  logic [7:0] next_off_dst;
  logic [7:0] next_imm;
  logic next_addr_used;
  logic pfx_ok;

  // Two cases over the leading byte, high nibble or group; prefixes are checked afterwards
  always_comb begin
    next_form = FORM_ILLEGAL;
    next_src = SPC_NONE;
    next_dst = SPC_NONE;
    next_len = '0;
    next_reg_a = '0;
    next_reg_b = '0;
    next_mode = '0;
    next_off_src = '0;
    next_off_dst = '0;
    next_imm = '0;
    next_addr_used = 1'b0;
    if (alu_ok && alu_single) begin
      case (hi0)
        HI_ACC_IMM: begin
          next_form = FORM_ACC_IMM;
          next_imm = cb[1];
          next_len = LEN_TWO;
        end
        HI_REG: begin
          next_reg_a = cb[1][7:4];
          next_len = LEN_THREE;
          next_off_src = cb[2];
          next_off_dst = cb[2];
          case (lo1)
            SEL_IMM: begin
              next_form = FORM_REG_IMM;
              next_imm = cb[2];
              next_off_src = '0;
              next_off_dst = '0;
            end
            SEL_RD_P2: {next_form, next_src} = {FORM_REG_MEM_RD, SPC_PAGE2};
            SEL_RD_P1: {next_form, next_src} = {FORM_REG_MEM_RD, SPC_PAGE1};
            SEL_RD_SFR: {next_form, next_src} = {FORM_REG_MEM_RD, SPC_SFR};
            SEL_WR_P2: {next_form, next_dst} = {FORM_REG_MEM_WR, SPC_PAGE2};
            SEL_WR_P1: {next_form, next_dst} = {FORM_REG_MEM_WR, SPC_PAGE1};
            SEL_WR_SFR: {next_form, next_dst} = {FORM_REG_MEM_WR, SPC_SFR};
            default: next_form = FORM_ILLEGAL;
          endcase
          if (next_dst == SPC_NONE) next_off_dst = '0;
          if (next_src == SPC_NONE) next_off_src = '0;
        end
        HI_MEM_IMM: begin
          next_form = FORM_MEM_IMM;
          next_dst = sfr ? SPC_SFR : (page1 ? SPC_PAGE1 : SPC_PAGE2);
          next_off_dst = cb[1];
          next_imm = cb[2];
          next_len = LEN_THREE;
        end
        HI_REG_REG: begin
          // Register byte carries a zero in bit 3
          if (!cb[1][RSEL_ZERO_BIT]) begin
            next_form = page1 ? FORM_REG_REG2 : FORM_REG_REG;
            next_reg_a = cb[1][7:4];
            next_reg_b = cb[1][2:0];
            next_len = LEN_TWO;
          end
        end
        HI_ACC_SADDR: begin
          next_form = FORM_ACC_SADDR;
          next_src = SPC_PAGE2;
          next_off_src = cb[1];
          next_len = LEN_TWO;
        end
        default: next_form = FORM_ILLEGAL;
      endcase
    end else if (alu_ok) begin
      case (cb[0])
        GRP_MEMMEM: begin
          if (hi1 <= MEMMEM_LAST) begin
            next_form = FORM_MEM_MEM;
            next_dst = hi1[1] ? SPC_PAGE1 : SPC_PAGE2;
            next_src = hi1[0] ? SPC_PAGE1 : SPC_PAGE2;
            next_off_src = cb[2];
            next_off_dst = cb[3];
            next_len = LEN_FOUR;
          end
        end
        GRP_IND: begin
          next_len = LEN_THREE;
          case (hi1)
            IND_WLOAD: next_form = FORM_IND_WLOAD;
            IND_WSTORE: next_form = FORM_IND_WSTORE;
            IND_LLOAD: next_form = FORM_IND_LLOAD;
            IND_LSTORE: next_form = FORM_IND_LSTORE;
            default: next_form = FORM_ILLEGAL;
          endcase
          // Pointer sits in short direct space; offset is the last byte
          if (hi1[DIR_BIT]) begin
            next_dst = page_space_p1 ? SPC_PAGE1 : SPC_PAGE2;
            next_off_dst = cb[2];
          end else begin
            next_src = page_space_p1 ? SPC_PAGE1 : SPC_PAGE2;
            next_off_src = cb[2];
          end
        end
        GRP_ABS: begin
          next_addr_used = 1'b1;
          next_mode = hi1;
          case (hi1)
            ABS16_LD: {next_form, next_len} = {FORM_ABS16_LD, LEN_FOUR};
            ABS24_LD: {next_form, next_len} = {FORM_ABS24_LD, LEN_FIVE};
            ABS16_ST: {next_form, next_len} = {FORM_ABS16_ST, LEN_FOUR};
            ABS24_ST: {next_form, next_len} = {FORM_ABS24_ST, LEN_FIVE};
            default: begin
              // Index nibble 0..3 loads, 8..B stores
              if (hi1[2]) begin
                next_form = FORM_ILLEGAL;
              end else begin
                next_form = hi1[DIR_BIT] ? FORM_IDX24_ST : FORM_IDX24_LD;
                next_len = LEN_FIVE;
              end
            end
          endcase
        end
        GRP_REGIND: begin
          next_form = hi1[DIR_BIT] ? FORM_REGIND_ST : FORM_REGIND_LD;
          next_mode = hi1;
          next_len = LEN_TWO;
        end
        GRP_DISP: begin
          if (hi1[2:0] <= DISP_LAST) begin
            next_form = hi1[DIR_BIT] ? FORM_DISP_ST : FORM_DISP_LD;
            next_mode = hi1;
            next_off_src = cb[2];
            next_len = LEN_THREE;
          end
        end
        GRP_BASEIDX: begin
          next_form = hi1[DIR_BIT] ? FORM_BASEIDX_ST : FORM_BASEIDX_LD;
          next_mode = hi1;
          next_len = LEN_TWO;
        end
        default: next_form = FORM_ILLEGAL;
      endcase
    end
  end

  // Prefix legality: special prefix only before 6x; page one before 6x,
  // 8x or the pointer group
  wire form_mem_imm = (next_form == FORM_MEM_IMM);
  wire form_ind = (next_form == FORM_IND_WLOAD) |
    (next_form == FORM_IND_WSTORE) | (next_form == FORM_IND_LLOAD) |
    (next_form == FORM_IND_LSTORE);
  assign pfx_ok = !pfx_any | form_mem_imm |
    (page1 & ((next_form == FORM_REG_REG2) | form_ind));
  wire dec_ok = (next_form != FORM_ILLEGAL) & pfx_ok;
  wire [2:0] total_len = pfx_any ? next_len + LEN_PFX : next_len;

  // ***************************************************************
  // Output registers
  // ***************************************************************
  // Fields load only on a strobe, so they hold for the execute stage
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dec_valid_o <= 1'b0;
      illegal_o <= 1'b0;
      is_cmp_o <= 1'b0;
      writes_dst_o <= 1'b0;
      form_o <= FORM_ILLEGAL;
      src_space_o <= SPC_NONE;
      dst_space_o <= SPC_NONE;
      length_o <= '0;
      reg_a_o <= '0;
      reg_b_o <= '0;
      mode_o <= '0;
      off_src_o <= '0;
      off_dst_o <= '0;
      imm_o <= '0;
      addr_o <= '0;
    end else begin
      dec_valid_o <= insn_valid_i;
      if (insn_valid_i) begin
        illegal_o <= !dec_ok;
        is_cmp_o <= dec_ok & (alu_nib == ALU_CMP);
        writes_dst_o <= dec_ok & (alu_nib == ALU_AND);
        form_o <= dec_ok ? next_form : FORM_ILLEGAL;
        src_space_o <= next_src;
        dst_space_o <= next_dst;
        length_o <= dec_ok ? total_len : '0;
        reg_a_o <= next_reg_a;
        reg_b_o <= next_reg_b;
        mode_o <= next_mode;
        off_src_o <= next_off_src;
        off_dst_o <= next_off_dst;
        imm_o <= next_imm;
        addr_o <= next_addr_used ? packed_addr : '0;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb_clk @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_in(logic [7:0] b0);
    insn_valid_i && rb[0] == b0;
  endsequence

  sequence s_pfx_in(logic [7:0] p, logic [7:0] b1);
    insn_valid_i && rb[0] == p && rb[1] == b1;
  endsequence

  acc_imm_a: assert property (s_in({HI_ACC_IMM, ALU_AND}) |=>
    dec_valid_o && form_o == FORM_ACC_IMM && imm_o == $past(rb[1])
    && length_o == LEN_TWO) else $error("acc imm decode wrong");
  reg_imm_a: assert property (s_in({HI_REG, ALU_AND})
    ##0 rb[1][3:0] == SEL_IMM |=> form_o == FORM_REG_IMM
    && reg_a_o == $past(rb[1][7:4]) && imm_o == $past(rb[2]))
    else $error("reg imm decode wrong");
  page2_imm_a: assert property (s_in({HI_MEM_IMM, ALU_AND}) |=>
    form_o == FORM_MEM_IMM && dst_space_o == SPC_PAGE2
    && off_dst_o == $past(rb[1]) && imm_o == $past(rb[2]))
    else $error("page two imm decode wrong");
  page1_imm_a: assert property (s_pfx_in(PFX_PAGE1,
    {HI_MEM_IMM, ALU_AND}) |=> dst_space_o == SPC_PAGE1
    && off_dst_o == $past(rb[2]) && imm_o == $past(rb[3])
    && length_o == LEN_FOUR) else $error("page one imm decode wrong");
  sfr_imm_a: assert property (s_pfx_in(PFX_SFR,
    {HI_MEM_IMM, ALU_AND}) |=> dst_space_o == SPC_SFR && !illegal_o
    && off_dst_o == $past(rb[2])) else $error("sfr imm decode wrong");
  acc_saddr_a: assert property (s_in({HI_ACC_SADDR, ALU_AND}) |=>
    form_o == FORM_ACC_SADDR && off_src_o == $past(rb[1]))
    else $error("acc saddr decode wrong");
  reg_write_a: assert property (s_in({HI_REG, ALU_AND})
    ##0 rb[1][3:0] == SEL_WR_P1 |=> form_o == FORM_REG_MEM_WR
    && dst_space_o == SPC_PAGE1) else $error("reg write decode wrong");
  memmem_order_a: assert property (s_pfx_in(GRP_MEMMEM,
    {4'h1, ALU_AND}) |=> off_src_o == $past(rb[2])
    && off_dst_o == $past(rb[3]) && src_space_o == SPC_PAGE1)
    else $error("mem mem order wrong");
  abs24_order_a: assert property (s_pfx_in(GRP_ABS,
    {ABS24_LD, ALU_AND}) |=> addr_o == {$past(rb[2]), $past(rb[4]),
    $past(rb[3])} && length_o == LEN_FIVE)
    else $error("abs24 byte order wrong");
  cmp_flags_a: assert property (insn_valid_i && !alu_single
    && lo1 == ALU_CMP && dec_ok |=> is_cmp_o && !writes_dst_o)
    else $error("compare must not write operand");
endmodule : aoc_decoder

// ### aoc_fetch_model.sv
// Fetch-side model that hands whole instructions to the decoder
`timescale 1ns/100ps
module aoc_fetch_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Request from the bench
  input wire logic req_valid_i,
  input wire logic [aoc_pkg::BUS_W-1:0] req_bytes_i,
  // Instruction strobe towards the decoder
  output logic insn_valid_o,
  output logic [aoc_pkg::BUS_W-1:0] insn_bytes_o
);
  import aoc_pkg::*;
  // One strobe per request; lanes invert between strobes so that
  // the decoder cannot lean on stale bytes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      insn_valid_o <= 1'h0;
      insn_bytes_o <= '0;
    end else begin
      insn_valid_o <= req_valid_i;
      insn_bytes_o <= req_valid_i ? req_bytes_i : ~insn_bytes_o;
    end
  end
endmodule : aoc_fetch_model

// ### aoc_decoder_tb.sv
// Self-checking bench for the AND / compare opcode decoder
`timescale 1ns/100ps
module aoc_decoder_tb;
  import aoc_pkg::*;
  // ***************************************************************
  // Signals and scoreboard
  // ***************************************************************
  typedef struct {
    aoc_form_t form;
    logic [2:0] len;
    logic cmp;
    int sel;
    logic [23:0] val;
  } aoc_exp_t;
  logic core_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic req_valid = 1'h0;
  logic [BUS_W-1:0] req_bytes = '0;
  logic insn_valid;
  logic [BUS_W-1:0] insn_bytes;
  logic dec_valid_o, illegal_o, is_cmp_o, writes_dst_o;
  aoc_form_t form_o;
  aoc_space_t src_space_o, dst_space_o;
  logic [2:0] length_o, reg_b_o;
  logic [3:0] reg_a_o, mode_o, a;
  logic [7:0] off_src_o, off_dst_o, imm_o, x, y, z;
  logic [23:0] addr_o;
  logic c;
  aoc_exp_t q[$];
  aoc_exp_t m;
  int seed = 73541;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  aoc_fetch_model aoc_fetch_model_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .req_valid_i(req_valid),
    .req_bytes_i(req_bytes), .insn_valid_o(insn_valid),
    .insn_bytes_o(insn_bytes));
  aoc_decoder aoc_decoder_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .insn_valid_i(insn_valid),
    .insn_bytes_i(insn_bytes), .dec_valid_o(dec_valid_o),
    .illegal_o(illegal_o), .is_cmp_o(is_cmp_o),
    .writes_dst_o(writes_dst_o), .form_o(form_o),
    .src_space_o(src_space_o), .dst_space_o(dst_space_o),
    .length_o(length_o), .reg_a_o(reg_a_o), .reg_b_o(reg_b_o),
    .mode_o(mode_o), .off_src_o(off_src_o), .off_dst_o(off_dst_o),
    .imm_o(imm_o), .addr_o(addr_o));

  // 125 MHz clock
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [23:0] s,
    input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Note the expectation, then strobe; lanes past the end are random
  task automatic put(input logic [55:0] b, input int n, input aoc_form_t f,
    input logic cm, input int sel, input logic [23:0] v);
    logic [55:0] bb;
    aoc_exp_t e;
    bb = b;
    for (int k = n; k < 7; k++) bb[8*k+:8] = 8'($random(seed));
    e.form = f;
    e.len = (f == FORM_ILLEGAL) ? 3'h0 : 3'(n);
    e.cmp = (f != FORM_ILLEGAL) && cm;
    e.sel = sel;
    e.val = v;
    q.push_back(e);
    @(posedge core_clk_i);
    req_valid <= 1'h1;
    req_bytes <= bb;
  endtask : put

  function automatic logic [23:0] got(input int sel);
    case (sel)
      1: got = 24'(imm_o);
      2: got = addr_o;
      3: got = 24'(off_src_o);
      4: got = 24'(off_dst_o);
      5: got = 24'(reg_a_o);
      6: got = {4'h0, src_space_o, dst_space_o, off_dst_o, off_src_o};
      8: got = 24'({reg_a_o, 1'h0, reg_b_o});
      default: got = 24'(mode_o);
    endcase
  endfunction : got

  // Monitor: outputs settled at the falling edge
  always @(negedge core_clk_i) begin
    if (dec_valid_o === 1'h1) begin
      if (q.size() == 0) chk("spare_strobe", 24'h1, 24'h0);
      else begin
        m = q.pop_front();
        chk("form", 24'(form_o), 24'(m.form));
        chk("length", 24'(length_o), 24'(m.len));
        chk("cmp", 24'(is_cmp_o), 24'(m.cmp));
        chk("writes", 24'(writes_dst_o),
          24'(m.form != FORM_ILLEGAL && !m.cmp));
        chk("illegal", 24'(illegal_o), 24'(m.form == FORM_ILLEGAL));
        if (m.sel != 0) chk("field", got(m.sel), m.val);
      end
    end
  end

  // Hang guard, well above the roughly 180 cycles needed
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end

  // ***************************************************************
  // Main sequence, AND pass then compare pass
  // ***************************************************************
  initial begin
    repeat (16) @(posedge core_clk_i);
    chk("reset_valid", 24'(dec_valid_o), 24'h0);
    chk("reset_form", 24'(form_o), 24'(FORM_ILLEGAL));
    reset_n_i <= 1'h1;
    for (int ai = 0; ai < 2; ai++) begin
      a = ai ? ALU_CMP : ALU_AND;
      c = ai[0];
      x = 8'($random(seed));
      y = 8'($random(seed));
      z = 8'($random(seed));
      put({x, HI_ACC_IMM, a}, 2, FORM_ACC_IMM, c, 1, x);
      put({x, y[7:4], SEL_IMM, HI_REG, a}, 3, FORM_REG_IMM, c, 1,
        x);
      put({x, y, HI_MEM_IMM, a}, 3, FORM_MEM_IMM, c, 1, x);
      put({x, y, HI_MEM_IMM, a, PFX_PAGE1}, 4, FORM_MEM_IMM, c, 1,
        x);
      put({x, y, HI_MEM_IMM, a, PFX_SFR}, 4, FORM_MEM_IMM, c, 1,
        x);
      put({y, HI_ACC_SADDR, a}, 2, FORM_ACC_SADDR, c, 3, y);
      for (int k = 0; k < 7; k++) if (k != 3) put({y, x[3:0], k[3:0],
        HI_REG, a}, 3, k < 3 ? FORM_REG_MEM_RD : FORM_REG_MEM_WR, c, 5,
        24'(x[3:0]));
      // Register pair forms, plain and behind the page-one prefix
      put({y[7:4], 1'h0, x[2:0], HI_REG_REG, a}, 2, FORM_REG_REG, c, 8,
        24'({y[7:4], 1'h0, x[2:0]}));
      put({y[7:4], 1'h0, x[2:0], HI_REG_REG, a, PFX_PAGE1}, 3,
        FORM_REG_REG2, c, 8, 24'({y[7:4], 1'h0, x[2:0]}));
      for (int k = 0; k < 4; k++) put({z, y, k[3:0], a, GRP_MEMMEM}, 4,
        FORM_MEM_MEM, c, 6, {4'h0, k[0] ? SPC_PAGE1 : SPC_PAGE2,
        k[1] ? SPC_PAGE1 : SPC_PAGE2, z, y});
      put({y, IND_WLOAD, a, GRP_IND}, 3, FORM_IND_WLOAD, c, 3, y);
      put({y, IND_WSTORE, a, GRP_IND}, 3, FORM_IND_WSTORE, c, 4,
        y);
      put({y, IND_WLOAD, a, GRP_IND, PFX_PAGE1}, 4, FORM_IND_WLOAD, c, 3,
        y);
      put({y, IND_LLOAD, a, GRP_IND}, 3, FORM_IND_LLOAD, c, 3, y);
      put({y, IND_LSTORE, a, GRP_IND}, 3, FORM_IND_LSTORE, c, 4,
        y);
      put({y, x, ABS16_LD, a, GRP_ABS}, 4, FORM_ABS16_LD, c, 2,
        {8'h00, y, x});
      put({z, y, x, ABS24_LD, a, GRP_ABS}, 5, FORM_ABS24_LD, c, 2,
        {x, z, y});
      put({y, x, ABS16_ST, a, GRP_ABS}, 4, FORM_ABS16_ST, c, 2,
        {8'h00, y, x});
      put({z, y, x, ABS24_ST, a, GRP_ABS}, 5, FORM_ABS24_ST, c, 2,
        {x, z, y});
      for (int k = 0; k < 16; k++) begin
        put({k[3:0], a, GRP_REGIND}, 2,
          k < 8 ? FORM_REGIND_LD : FORM_REGIND_ST, c, 7, 24'(k));
        put({k[3:0], a, GRP_BASEIDX}, 2, k < 8 ? FORM_BASEIDX_LD :
          FORM_BASEIDX_ST, c, 7, 24'(k));
        if (k[2:0] <= 3'h4) put({y, k[3:0], a, GRP_DISP}, 3,
          k < 8 ? FORM_DISP_LD : FORM_DISP_ST, c, 3, 24'(y));
        if (k[2:0] < 3'h4) put({z, y, x, k[3:0], a, GRP_ABS}, 5,
          k < 8 ? FORM_IDX24_LD : FORM_IDX24_ST, c, 2, {z, y, x});
      end
    end
    // Encodings outside the AND / compare set
    put({8'h6C, GRP_ABS}, 2, FORM_ILLEGAL, 1'h0, 0, 24'h0);
    put({8'h12, 8'hAE}, 2, FORM_ILLEGAL, 1'h0, 0, 24'h0);
    put({8'h9C, PFX_SFR}, 2, FORM_ILLEGAL, 1'h0, 0, 24'h0);
    @(posedge core_clk_i);
    req_valid <= 1'h0;
    repeat (6) @(posedge core_clk_i);
    chk("pending", 24'(q.size()), 24'h0);
    stop_test;
  end
endmodule : aoc_decoder_tb
